// ==== common/rxso_pkg.sv ====
package rxso_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int NUM_CH_DEF = 22;
  localparam int PAD_SLOTS = 7;
  localparam int FRAME_LEN = NUM_CH_DEF + PAD_SLOTS;
  localparam int SLOT_W = 5;
  localparam int T1_HZ = 1_544_000;
  localparam int E1_HZ = 2_048_000;
  localparam int REF_SLOW_HZ = 8_000;
  localparam int REF_FAST_HZ = 2_048_000;
  localparam int ACC_W = 32;
  localparam logic [ACC_W-1:0] INC_T1 = ACC_W'({32'(T1_HZ), 32'h0} / CLK_HZ);
  localparam logic [ACC_W-1:0] INC_E1 = ACC_W'({32'(E1_HZ), 32'h0} / CLK_HZ);
  localparam logic [ACC_W-1:0] INC_REF_SLOW = ACC_W'({32'(REF_SLOW_HZ), 32'h0} / CLK_HZ);
  localparam logic [ACC_W-1:0] INC_REF_FAST = ACC_W'({32'(REF_FAST_HZ), 32'h0} / CLK_HZ);
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] REG_GLOBAL = 6'h00;
  localparam logic [IDX_W-1:0] REG_STATUS = 6'h01;
  localparam logic [IDX_W-1:0] REG_CFG_BASE = 6'h02;
  localparam int GB_REF_EN = 0;
  localparam int GB_REF_FAST = 1;
  localparam int GB_E1 = 2;
  localparam int GB_W = 3;
  localparam logic [GB_W-1:0] GLOBAL_RST = 3'h0;
  localparam int C0_FMT_LSB = 0;
  localparam int C0_FMT_MSB = 1;
  localparam int C0_PWRDN = 5;
  localparam int C0_FLOAT = 6;
  localparam int C0_HOLD = 7;
  localparam int C1_INV = 3;
  localparam int C1_EDGE = 4;
  localparam int C1_SEL_LSB = 5;
  localparam int C1_SEL_MSB = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  typedef enum logic [1:0] {FMT_SR, FMT_DNRZ, FMT_DRZ, FMT_SLICED} rxso_fmt_t;
  typedef enum logic [2:0] {
    IND_PATTERN, IND_AIS, IND_EXZ, IND_BPV, IND_EXZ_BPV, IND_LOS, IND_CLOCK, IND_SLICED_XOR
  } rxso_ind_t;
  typedef struct packed {
    logic rclk;
    logic dec;
    logic pos;
    logic neg;
    logic spos;
    logic sneg;
    logic los;
    logic patt;
    logic ais;
    logic exz;
    logic bpv;
  } rxso_line_t;
endpackage : rxso_pkg

// ==== tb/rxso_framer_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rxso_framer_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ref_i,
  input wire logic ser_i,
  input wire logic mark_i,
  output logic [21:0] frame_los_o,
  output int frames_o,
  output int err_o
);
  logic ref_q;
  logic aligned;
  logic [4:0] slot;
  logic [21:0] acc;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_q <= 1'b0;
      aligned <= 1'b0;
      slot <= 5'h00;
      acc <= '0;
      frame_los_o <= '0;
      frames_o <= 0;
      err_o <= 0;
    end else begin
      ref_q <= ref_i;
      // Sample on the falling edge, half a period clear of the update edge
      if (ref_q && !ref_i) begin
        if (mark_i) begin
          if (aligned && slot != 5'h1D) begin
            err_o <= err_o + 1;
          end
          aligned <= 1'b1;
          acc[0] <= ser_i;
          slot <= 5'h01;
        end else if (aligned) begin
          if (slot == 5'h1D) begin
            err_o <= err_o + 1;
          end else if (slot < 5'h16) begin
            acc[slot] <= ser_i;
          end else if (ser_i) begin
            err_o <= err_o + 1;
          end
          if (slot == 5'h1C) begin
            frame_los_o <= acc;
            frames_o <= frames_o + 1;
          end
          slot <= slot + 5'h01;
        end
      end
    end
  end
endmodule : rxso_framer_model
`default_nettype wire

// ==== tb/test_rx_system_output_and_los_serializer.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_rx_system_output_and_los_serializer;
  import rxso_pkg::*;
  localparam logic [21:0] LOS_PAT = 22'h25A5C3;
  localparam logic [7:0] IND_EXP = 8'h95;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rxso_line_t [21:0] line_i = '0;
  logic [21:0] pos_o, pos_oe, neg_o, neg_oe, rck_o, rck_oe;
  logic ref_o, ser_o, ser_oe, mark_o, mark_oe;
  logic [21:0] frame_los;
  int frames, ferr, n;
  int n_mismatch = 0;
  int check_count = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  rxso_rx_sys_out #(.NUM_CH(22)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_i(line_i), .rx_positive_rail_o(pos_o),
    .rx_positive_rail_oe_o(pos_oe), .rx_negative_rail_o(neg_o),
    .rx_negative_rail_oe_o(neg_oe), .rx_recovered_clock_o(rck_o),
    .rx_recovered_clock_oe_o(rck_oe), .reference_clock_out_o(ref_o),
    .line_loss_serial_o(ser_o), .line_loss_serial_oe_o(ser_oe),
    .channel_zero_marker_o(mark_o), .channel_zero_marker_oe_o(mark_oe));
  rxso_framer_model framer_u (.clk_i(clk_i), .reset_i(reset_i), .ref_i(ref_o),
    .ser_i(ser_o), .mark_i(mark_o), .frame_los_o(frame_los), .frames_o(frames),
    .err_o(ferr));
  task automatic results();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      chk(32'h1, 32'h0);
      results();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic rtick(input logic v);
    line_i[0].rclk <= v;
    repeat (8) @(posedge clk_i);
  endtask : rtick
  // Rising edges of the channel 0 clock pin over 1000 master cycles
  task automatic rises(output int c);
    logic p;
    c = 0;
    p = rck_o[0];
    repeat (1000) begin
      @(posedge clk_i);
      if (rck_o[0] && !p) c++;
      p = rck_o[0];
    end
  endtask : rises
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h00, 32'h0);
    chk(ser_oe | mark_oe, 0);
    rd(8'h0C, 32'h0);
    rd(8'hFC, 32'h0);
    line_i[0].dec <= 1'b1;
    line_i[0].patt <= 1'b1;
    line_i[0].exz <= 1'b1;
    line_i[0].spos <= 1'b1;
    // Invert set throughout: indication must ignore it
    for (int s = 0; s < 8; s++) begin
      wr(8'h0C, {24'h0, s[2:0], 5'h08});
      rtick(1'b1);
      rtick(1'b0);
      chk(neg_o[0], IND_EXP[s]);
    end
    chk(pos_o[0], 0);
    // Clear the held data so the later edge-select check can tell edges apart
    line_i[0].dec <= 1'b0;
    rtick(1'b1);
    rtick(1'b0);
    chk(pos_o[0], 1);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h10);
    line_i[0].pos <= 1'b1;
    rtick(1'b1);
    chk(pos_o[0], 0);
    chk(rck_o[0], 1);
    rtick(1'b0);
    chk({pos_o[0], neg_o[0]}, 2'b10);
    line_i[0].pos <= 1'b0;
    line_i[0].neg <= 1'b1;
    rtick(1'b1);
    rtick(1'b0);
    chk({pos_o[0], neg_o[0]}, 2'b01);
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'h0);
    line_i[0].pos <= 1'b1;
    line_i[0].neg <= 1'b0;
    rtick(1'b1);
    chk(pos_o[0], 1);
    rtick(1'b0);
    chk(pos_o[0], 0);
    wr(8'h08, 32'h3);
    wr(8'h0C, 32'hE0);
    line_i[0].spos <= 1'b0;
    line_i[0].sneg <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({pos_o[0], neg_o[0]}, 2'b01);
    chk(rck_o[0], 1);
    wr(8'h08, 32'h60);
    repeat (2) @(posedge clk_i);
    chk({pos_oe[0], neg_oe[0], rck_oe[0]}, 0);
    wr(8'h08, 32'h20);
    repeat (2) @(posedge clk_i);
    chk({pos_oe[0], neg_oe[0], rck_oe[0], pos_o[0], neg_o[0], rck_o[0]}, 6'h38);
    wr(8'h08, 32'h80);
    line_i[0].los <= 1'b1;
    repeat (8) @(posedge clk_i);
    rises(n);
    chk({n != 0, rck_o[0]}, 1);
    wr(8'h08, 32'h0);
    rises(n);
    chk(n >= 15 && n <= 16, 1);
    wr(8'h00, 32'h4);
    rises(n);
    chk(n >= 20 && n <= 21, 1);
    for (int c = 0; c < 22; c++) line_i[c].los <= LOS_PAT[c];
    repeat (8) @(posedge clk_i);
    rd(8'h04, {10'h0, LOS_PAT});
    wr(8'h00, 32'h3);
    n = 0;
    while (frames < 2 && n < 8000) begin
      @(posedge clk_i);
      n++;
    end
    if (frames < 2) begin
      chk(32'h1, 32'h0);
      results();
    end
    chk(frames >= 2, 1);
    chk(frame_los, LOS_PAT);
    chk(ferr, 0);
    chk({ser_oe, mark_oe}, 2'b11);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({ser_oe, mark_oe}, 2'b00);
    results();
  end
endmodule : test_rx_system_output_and_los_serializer
`default_nettype wire

// ==== verilog/rxso_rx_sys_out.sv ====
`timescale 1ns/1ns
`default_nettype none
module rxso_rx_sys_out
  import rxso_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire rxso_line_t [NUM_CH-1:0] line_i,
  output logic [NUM_CH-1:0] rx_positive_rail_o,
  output logic [NUM_CH-1:0] rx_positive_rail_oe_o,
  output logic [NUM_CH-1:0] rx_negative_rail_o,
  output logic [NUM_CH-1:0] rx_negative_rail_oe_o,
  output logic [NUM_CH-1:0] rx_recovered_clock_o,
  output logic [NUM_CH-1:0] rx_recovered_clock_oe_o,
  output logic reference_clock_out_o,
  output logic line_loss_serial_o,
  output logic line_loss_serial_oe_o,
  output logic channel_zero_marker_o,
  output logic channel_zero_marker_oe_o
);
  localparam int LW = $bits(rxso_line_t);

  // Three-stage capture; a change counts once stages two and three agree
  logic [NUM_CH*LW-1:0] s1, s2, s3, st;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      st <= '0;
    end else if (ce_i) begin
      s1 <= line_i;
      s2 <= s1;
      s3 <= s2;
      st <= (s2 & ~(s2 ^ s3)) | (st & (s2 ^ s3));
    end
  end
  rxso_line_t [NUM_CH-1:0] line_q;
  assign line_q = st;

  // Register file
  logic [GB_W-1:0] glob;
  logic [7:0] cfg0 [NUM_CH];
  logic [7:0] cfg1 [NUM_CH];
  logic [NUM_CH-1:0] los_vec;
  logic ack;
  logic [IDX_W-1:0] idx;
  logic in_cfg;
  logic [IDX_W-1:0] cfg_off;
  logic [DATA_W-1:0] next_rdata;
  assign idx = avs_address[ADDR_W-1:2];
  assign cfg_off = idx - REG_CFG_BASE;
  assign in_cfg = (idx >= REG_CFG_BASE) && (cfg_off < IDX_W'(2 * NUM_CH));
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack <= 1'b0;
    end else if (ce_i) begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (idx == REG_GLOBAL) begin
      next_rdata[GB_W-1:0] = glob;
    end else if (idx == REG_STATUS) begin
      next_rdata[NUM_CH-1:0] = los_vec;
    end else if (in_cfg) begin
      next_rdata[7:0] = cfg_off[0] ? cfg1[cfg_off[IDX_W-1:1]] : cfg0[cfg_off[IDX_W-1:1]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata <= '0;
    end else if (ce_i && avs_read && !ack) begin
      avs_readdata <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      glob <= GLOBAL_RST;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg0[c] <= CFG_RST;
        cfg1[c] <= CFG_RST;
      end
    end else if (ce_i && avs_write && ack) begin
      if (idx == REG_GLOBAL) begin
        glob <= avs_writedata[GB_W-1:0];
      end else if (in_cfg) begin
        if (cfg_off[0]) begin
          cfg1[cfg_off[IDX_W-1:1]] <= avs_writedata[7:0];
        end else begin
          cfg0[cfg_off[IDX_W-1:1]] <= avs_writedata[7:0];
        end
      end
    end
  end

  // Fractional dividers; edges jitter by one master cycle, average rate slightly low as increments are truncated
  logic [ACC_W-1:0] loc_acc, ref_acc, next_ref_acc;
  logic local_clk, ref_q, ref_tick;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      loc_acc <= '0;
    end else if (ce_i) begin
      loc_acc <= loc_acc + (glob[GB_E1] ? INC_E1 : INC_T1);
    end
  end
  assign local_clk = loc_acc[ACC_W-1];

  assign next_ref_acc = ref_acc + (glob[GB_REF_FAST] ? INC_REF_FAST : INC_REF_SLOW);
  assign ref_tick = glob[GB_REF_EN] & next_ref_acc[ACC_W-1] & ~ref_acc[ACC_W-1];
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_acc <= '0;
    end else if (ce_i) begin
      ref_acc <= glob[GB_REF_EN] ? next_ref_acc : '0;
    end
  end

  // Serial loss stream; while enabled, the serial and marker pins move with the reference rising edge
  logic [SLOT_W-1:0] slot;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slot <= '0;
      ref_q <= 1'b0;
      line_loss_serial_o <= 1'b0;
      channel_zero_marker_o <= 1'b0;
    end else if (ce_i) begin
      // Follow the new phase so the pin rises on the same edge as the serial update
      ref_q <= next_ref_acc[ACC_W-1] & glob[GB_REF_EN];
      if (!glob[GB_REF_EN]) begin
        slot <= '0;
        line_loss_serial_o <= 1'b0;
        channel_zero_marker_o <= 1'b0;
      end else if (ref_tick) begin
        slot <= (slot == SLOT_W'(FRAME_LEN - 1)) ? '0 : slot + 1'b1;
        line_loss_serial_o <= (slot < SLOT_W'(NUM_CH)) ? los_vec[slot] : 1'b0;
        channel_zero_marker_o <= (slot == '0);
      end
    end
  end
  assign reference_clock_out_o = ref_q;
  assign line_loss_serial_oe_o = glob[GB_REF_EN];
  assign channel_zero_marker_oe_o = glob[GB_REF_EN];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    rxso_fmt_t fmt;
    rxso_ind_t sel;
    logic clkl, prev, act, inv, pwrdn, rz_phase;
    logic pos_d, neg_d, ind_d, ind_now, ind_pin;
    assign los_vec[c] = line_q[c].los;
    assign fmt = rxso_fmt_t'(cfg0[c][C0_FMT_MSB:C0_FMT_LSB]);
    assign sel = rxso_ind_t'(cfg1[c][C1_SEL_MSB:C1_SEL_LSB]);
    assign inv = cfg1[c][C1_INV];
    assign pwrdn = cfg0[c][C0_PWRDN];
    assign clkl = line_q[c].rclk;
    assign act = cfg1[c][C1_EDGE] ? (prev & ~clkl) : (~prev & clkl);
    // RZ pulse fills the half period after the active edge
    assign rz_phase = cfg1[c][C1_EDGE] ? ~clkl : clkl;

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        prev <= 1'b0;
      end else if (ce_i) begin
        prev <= clkl;
      end
    end

    always_comb begin
      case (sel)
        IND_PATTERN: ind_now = line_q[c].patt;
        IND_AIS: ind_now = line_q[c].ais;
        IND_EXZ: ind_now = line_q[c].exz;
        IND_BPV: ind_now = line_q[c].bpv;
        IND_EXZ_BPV: ind_now = line_q[c].exz | line_q[c].bpv;
        IND_LOS: ind_now = line_q[c].los;
        IND_SLICED_XOR: ind_now = line_q[c].spos ^ line_q[c].sneg;
        default: ind_now = 1'b0;
      endcase
    end
    assign ind_pin = (sel == IND_CLOCK) ? clkl : ind_d;

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        pos_d <= 1'b0;
        neg_d <= 1'b0;
        ind_d <= 1'b0;
      end else if (ce_i && act) begin
        pos_d <= (fmt == FMT_SR) ? line_q[c].dec : line_q[c].pos;
        neg_d <= line_q[c].neg;
        ind_d <= ind_now;
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        rx_positive_rail_o[c] <= 1'b0;
        rx_negative_rail_o[c] <= 1'b0;
        rx_recovered_clock_o[c] <= 1'b0;
        rx_positive_rail_oe_o[c] <= 1'b0;
        rx_negative_rail_oe_o[c] <= 1'b0;
        rx_recovered_clock_oe_o[c] <= 1'b0;
      end else if (ce_i) begin
        rx_positive_rail_oe_o[c] <= ~(pwrdn & cfg0[c][C0_FLOAT]);
        rx_negative_rail_oe_o[c] <= ~(pwrdn & cfg0[c][C0_FLOAT]);
        rx_recovered_clock_oe_o[c] <= ~(pwrdn & cfg0[c][C0_FLOAT]);
        if (pwrdn) begin
          rx_positive_rail_o[c] <= 1'b0;
          rx_negative_rail_o[c] <= 1'b0;
          rx_recovered_clock_o[c] <= 1'b0;
        end else begin
          // Tip-positive pulses already arrive on pos, tip-negative on neg
          case (fmt)
            FMT_SR: begin
              rx_positive_rail_o[c] <= pos_d ^ inv;
              rx_negative_rail_o[c] <= ind_pin;
            end
            FMT_DNRZ: begin
              rx_positive_rail_o[c] <= pos_d ^ inv;
              rx_negative_rail_o[c] <= neg_d ^ inv;
            end
            FMT_DRZ: begin
              rx_positive_rail_o[c] <= (pos_d & rz_phase) ^ inv;
              rx_negative_rail_o[c] <= (neg_d & rz_phase) ^ inv;
            end
            default: begin
              rx_positive_rail_o[c] <= line_q[c].spos ^ inv;
              rx_negative_rail_o[c] <= line_q[c].sneg ^ inv;
            end
          endcase
          if (fmt == FMT_SLICED) begin
            rx_recovered_clock_o[c] <= ind_pin;
          end else if (line_q[c].los) begin
            rx_recovered_clock_o[c] <= cfg0[c][C0_HOLD] | local_clk;
          end else begin
            rx_recovered_clock_o[c] <= clkl;
          end
        end
      end
    end
  end

  // Checks, channel 0 stands for all channels
  logic ref_rise, marker_seen, ref_prev, marker_prev;
  logic [SLOT_W:0] rises;
  // Previous pin levels held in flops, so the edge helpers stay plain logic
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_prev <= 1'b0;
      marker_prev <= 1'b0;
    end else if (ce_i) begin
      ref_prev <= reference_clock_out_o;
      marker_prev <= channel_zero_marker_o;
    end
  end
  assign ref_rise = reference_clock_out_o & ~ref_prev;
  always_ff @(posedge clk_i) begin
    if (reset_i || !glob[GB_REF_EN]) begin
      rises <= '0;
      marker_seen <= 1'b0;
    end else if (ce_i && channel_zero_marker_o && !marker_prev) begin
      rises <= (SLOT_W + 1)'(1);
      marker_seen <= 1'b1;
    end else if (ce_i && ref_rise) begin
      rises <= rises + 1'b1;
    end
  end

  sequence s_ch0_live;
    !g_ch[0].pwrdn && ce_i;
  endsequence
  // Invert may be rewritten in single-rail mode; only a quiet window counts
  sequence s_sr_quiet;
    ce_i && !g_ch[0].pwrdn && g_ch[0].fmt == FMT_SR && !g_ch[0].act;
  endsequence
  sequence s_marker_start;
    ce_i && $rose(channel_zero_marker_o) && marker_seen;
  endsequence

  property p_sr_hold;
    @(posedge clk_i) disable iff (reset_i)
    s_sr_quiet ##1 s_sr_quiet ##0 $stable(g_ch[0].inv)
    |=> ce_i && $stable(rx_positive_rail_o[0]) || !ce_i;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("single-rail data moved off edge");
  property p_pwrdn_float;
    @(posedge clk_i) disable iff (reset_i)
    g_ch[0].pwrdn && ce_i |=> !rx_positive_rail_oe_o[0] == $past(cfg0[0][C0_FLOAT]) &&
      !rx_positive_rail_o[0] && !rx_recovered_clock_o[0];
  endproperty
  a_pwrdn_float: assert property (p_pwrdn_float) else $error("power-down output wrong");
  property p_sliced_pass;
    @(posedge clk_i) disable iff (reset_i)
    s_ch0_live and g_ch[0].fmt == FMT_SLICED |=>
      rx_negative_rail_o[0] == ($past(line_q[0].sneg) ^ $past(g_ch[0].inv));
  endproperty
  a_sliced_pass: assert property (p_sliced_pass) else $error("sliced rail not passed");
  property p_ind_pin;
    @(posedge clk_i) disable iff (reset_i)
    s_ch0_live and g_ch[0].fmt == FMT_SR |=> rx_negative_rail_o[0] == $past(g_ch[0].ind_pin);
  endproperty
  a_ind_pin: assert property (p_ind_pin) else $error("indication missing on shared pin");
  property p_los_hold;
    @(posedge clk_i) disable iff (reset_i)
    s_ch0_live and g_ch[0].fmt != FMT_SLICED && line_q[0].los && cfg0[0][C0_HOLD]
    |=> rx_recovered_clock_o[0];
  endproperty
  a_los_hold: assert property (p_los_hold) else $error("clock not held high in loss");
  property p_pad_low;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && ref_tick && slot >= SLOT_W'(NUM_CH) |=> !line_loss_serial_o;
  endproperty
  a_pad_low: assert property (p_pad_low) else $error("padding slot not low");
  property p_serial_on_rise;
    @(posedge clk_i) disable iff (reset_i)
    glob[GB_REF_EN] && $past(glob[GB_REF_EN]) && $changed(line_loss_serial_o) |-> ref_rise;
  endproperty
  a_serial_on_rise: assert property (p_serial_on_rise) else $error("serial moved off edge");
  property p_marker_on_rise;
    @(posedge clk_i) disable iff (reset_i)
    glob[GB_REF_EN] && $rose(channel_zero_marker_o) |-> ref_rise;
  endproperty
  a_marker_on_rise: assert property (p_marker_on_rise) else $error("marker moved off edge");
  property p_float_off;
    @(posedge clk_i) disable iff (reset_i)
    !glob[GB_REF_EN] |-> !line_loss_serial_oe_o && !channel_zero_marker_oe_o;
  endproperty
  a_float_off: assert property (p_float_off) else $error("serial pins driven while off");
  property p_marker_period;
    @(posedge clk_i) disable iff (reset_i)
    s_marker_start |-> rises == (SLOT_W + 1)'(FRAME_LEN) && ref_rise &&
      line_loss_serial_o == $past(los_vec[0]);
  endproperty
  a_marker_period: assert property (p_marker_period) else $error("marker period wrong");
endmodule : rxso_rx_sys_out
`default_nettype wire
